// ===== rtl/ebp_defs.svh
// register offsets, field positions, reset values and timing counts of the bridge pwm unit
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
`ifndef EBP_DEFS_SVH
`define EBP_DEFS_SVH

`define EBP_REG_CTRL        8'h00
`define EBP_REG_DUTY_RELOAD 8'h04
`define EBP_REG_DUTY_ACTIVE 8'h08
`define EBP_REG_PERIOD      8'h0c
`define EBP_REG_DEADBAND    8'h10
`define EBP_REG_TSEL        8'h14
`define EBP_REG_TCTRL       8'h18
`define EBP_REG_CMP         8'h1c
`define EBP_REG_T16A        8'h20
`define EBP_REG_T16B        8'h24
`define EBP_REG_STATUS      8'h28
`define EBP_REG_ALT_PERIOD  8'h2c
`define EBP_REG_PINDIR      8'h30

`define EBP_CTRL_RST        8'h00
`define EBP_PERIOD_RST      8'hff
`define EBP_PINDIR_RST      4'hf
`define EBP_TCTRL_RST       10'h000

`define EBP_MODE_CMP_SWI    4'ha
`define EBP_MODE_SPECIAL    4'hb
`define EBP_MODE_PWM_HI     2'h3
`define EBP_MODE_CMP_HI     2'h2

`define EBP_STAT_CMP        0
`define EBP_STAT_OVF_A      1
`define EBP_STAT_OVF_B      2
`define EBP_STAT_POST       3

`define EBP_QCYC_LAST       2'h3
`define EBP_PRE_MAX_1       4'h0
`define EBP_PRE_MAX_4       4'h3
`define EBP_PRE_MAX_16      4'hf
`define EBP_DB_MAX          7'h7f
`define EBP_DB_CNT_MAX      9'h1ff
`define EBP_DELAY_TAPS      4

`endif

// ===== rtl/ebp_pkg.sv
// types shared by the bridge pwm unit
// field layouts follow the constants in ebp_defs.svh
package ebp_pkg;

	// unit control register layout
	typedef struct packed {
		logic [1:0] out_cfg;
		logic [1:0] duty_lsb;
		logic [3:0] mode;
	} ebp_ctrl_type;

	// output configuration codes
	typedef enum logic [1:0] {
		EBP_CFG_SINGLE = 2'h0,
		EBP_CFG_FWD    = 2'h1,
		EBP_CFG_HALF   = 2'h2,
		EBP_CFG_REV    = 2'h3
	} ebp_cfg_type;

	// four bridge outputs
	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic d;
	} ebp_bridge_type;

	// avalon-mm slave request
	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} ebp_avs_req_type;

	// bus answer sequencer
	typedef enum logic [1:0] {
		EBP_BUS_IDLE = 2'b01,
		EBP_BUS_ACK  = 2'b10
	} ebp_bus_type;

endpackage

// ===== rtl/ebp_top.sv
// enhanced capture/compare/pwm unit with bridge outputs and special event trigger
// assumes an avalon-mm master on MCLK; MCLK is the oscillator, one instruction cycle is 4 MCLK
`timescale 1ns/1ns
`include "ebp_defs.svh"

module ebp_top #(
	parameter int UNIT_INDEX = 1
) (
	// clock and reset
	input  wire logic                    MCLK,
	input  wire logic                    RESET,
	// avalon-mm slave
	input  wire ebp_pkg::ebp_avs_req_type AVS_REQ,
	output logic [31:0]                  AVS_READDATA,
	output logic                         AVS_WAITREQUEST,
	// converter link
	input  wire logic                    ADC_ENABLE,
	output logic                         ADC_START,
	// bridge drivers
	output ebp_pkg::ebp_bridge_type      BRIDGE_OUT,
	output ebp_pkg::ebp_bridge_type      BRIDGE_OE
);
	import ebp_pkg::*;

	localparam logic HAS_TRIG = (UNIT_INDEX == 1) || (UNIT_INDEX == 2);
	localparam logic HAS_ADC  = (UNIT_INDEX == 2);

	// bus and software registers
	ebp_bus_type    bus_q;
	ebp_ctrl_type   ctrl_q;
	logic [7:0]     reload_q;
	logic [7:0]     period_q;
	logic [7:0]     alt_period_q;
	logic [6:0]     db_reg_q;
	logic [1:0]     tsel_q;
	logic [9:0]     tctrl_q;
	logic [15:0]    cmp_q;
	logic [3:0]     pindir_q;
	logic [3:0]     status_q;
	logic [31:0]    rdata_q;

	// timing state
	logic [1:0]     qcyc_q;
	logic [3:0]     presc_q;
	logic [7:0]     tmr_p_q;
	logic [7:0]     tmr_alt_q;
	logic [3:0]     post_q;
	logic [15:0]    t16a_q;
	logic [15:0]    t16b_q;
	logic           match_prev_q;
	logic           adc_q;

	// pwm state
	ebp_ctrl_type   sh_ctrl_q;
	logic [9:0]     duty_act_q;
	logic           run_q;
	logic           raw_q;
	logic [`EBP_DELAY_TAPS-1:0] lag_q;
	logic           mod_prev_q;
	logic [8:0]     db_cnt_q;
	logic [6:0]     db_act_q;
	ebp_bridge_type out_q;

	// merge a write into a register by byte lane
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// bus decode
	wire logic        acc     = AVS_REQ.read | AVS_REQ.write;
	wire logic        ack     = acc & (bus_q == EBP_BUS_ACK);
	wire logic        wr      = AVS_REQ.write & ack;
	wire logic [7:0]  adr     = AVS_REQ.address;
	wire logic [31:0] wd      = AVS_REQ.writedata;
	wire logic [3:0]  be      = AVS_REQ.byteenable;
	wire logic        wr_lo   = wr & be[0];
	wire logic [15:0] t16a_wr = lane_merge(t16a_q, wd, be);
	wire logic [15:0] t16b_wr = lane_merge(t16b_q, wd, be);
	wire logic [15:0] cmp_wr  = lane_merge(cmp_q, wd, be);

	// prescale, period-timer and postscale control
	wire logic [1:0] pre_sel  = tctrl_q[1:0];
	wire logic       ptmr_run = tctrl_q[2];
	wire logic [3:0] post_max = tctrl_q[6:3];
	wire logic       t16a_run = tctrl_q[7];
	wire logic       t16b_run = tctrl_q[8];

	// instruction cycle and prescaled tick
	wire logic       icyc    = (qcyc_q == `EBP_QCYC_LAST);
	wire logic [3:0] pre_max = (pre_sel == 2'h0) ? `EBP_PRE_MAX_1 :
		(pre_sel == 2'h1) ? `EBP_PRE_MAX_4 : `EBP_PRE_MAX_16;
	wire logic       ptick   = icyc & (presc_q == pre_max) & ptmr_run;

	wire logic       use_alt  = tsel_q[0];
	wire logic [7:0] pt       = use_alt ? tmr_alt_q : tmr_p_q;
	wire logic [7:0] plim     = use_alt ? alt_period_q : period_q;
	wire logic       wrap_p   = ptick & (tmr_p_q == period_q);
	wire logic       wrap_alt = ptick & (tmr_alt_q == alt_period_q);
	wire logic       boundary = ptick & (pt == plim);

	// quarter cycle or prescaler bits extend the timer
	wire logic [1:0] ext     = (pre_sel == 2'h0) ? qcyc_q :
		(pre_sel == 2'h1) ? presc_q[1:0] : presc_q[3:2];
	// a duty above the period never matches
	wire logic       duty_hit = (duty_act_q == {pt, ext});
	// a registered clear would add one cycle, so the match itself ends the pulse
	wire logic       raw_now  = raw_q & ~duty_hit;
	wire logic [9:0] duty_new = {reload_q, ctrl_q.duty_lsb};
	wire logic       pwm_mode = (ctrl_q.mode[3:2] == `EBP_MODE_PWM_HI);

	// compare and special trigger
	wire logic [15:0] cmp_tmr   = tsel_q[1] ? t16b_q : t16a_q;
	wire logic        match_now = (cmp_tmr == cmp_q);
	wire logic        cmp_mode  = (ctrl_q.mode[3:2] == `EBP_MODE_CMP_HI);
	wire logic        cmp_hit   = cmp_mode & match_now & ~match_prev_q;
	// units without trigger only flag the compare
	wire logic        trig      = cmp_hit & (ctrl_q.mode == `EBP_MODE_SPECIAL) & HAS_TRIG;
	wire logic        clr_a     = trig & ~tsel_q[1];
	wire logic        clr_b     = trig & tsel_q[1];
	wire logic        ovf_a     = t16a_run & icyc & (t16a_q == 16'hffff) & ~clr_a;
	wire logic        ovf_b     = t16b_run & icyc & (t16b_q == 16'hffff) & ~clr_b;
	wire logic        post_hit  = wrap_p & (post_q == post_max);

	// enhanced configurations lag by one instruction cycle
	wire logic mod   = (sh_ctrl_q.out_cfg == EBP_CFG_SINGLE) ? raw_now : lag_q[`EBP_DELAY_TAPS-1];
	// rising edges wait for the dead-band count
	// counted in oscillator cycles so the delay does not depend on the quarter-cycle phase
	wire logic settled = (mod == mod_prev_q) & (db_cnt_q >= {db_act_q, 2'b00}) | (db_act_q == 7'h00);
	// an output whose dead band outlasts its active time never rises
	wire logic hb_a  = mod & settled;
	wire logic hb_b  = ~mod & settled;

	// polarity from mode bits 1:0, a and c use bit 1, b and d bit 0
	wire logic inv_ac = sh_ctrl_q.mode[1];
	wire logic inv_bd = sh_ctrl_q.mode[0];
	ebp_bridge_type act;
	always_comb begin
		act = '0;
		case (sh_ctrl_q.out_cfg)
			EBP_CFG_SINGLE: begin
				act.a = mod;
			end
			EBP_CFG_HALF: begin
				act.a = hb_a;
				act.b = hb_b;
			end
			EBP_CFG_FWD: begin
				act.a = 1'b1;
				act.d = mod;
			end
			EBP_CFG_REV: begin
				act.c = 1'b1;
				act.b = mod;
			end
			default: begin
				act = '0;
			end
		endcase
		if (!run_q)
			act = '0;
	end
	wire ebp_bridge_type out_d = {act.a ^ inv_ac, act.b ^ inv_bd, act.c ^ inv_ac, act.d ^ inv_bd};

	// read mux
	logic [31:0] rdata_d;
	always_comb begin
		case (adr)
			`EBP_REG_CTRL:        rdata_d = {24'h000000, ctrl_q};
			`EBP_REG_DUTY_RELOAD: rdata_d = {24'h000000, reload_q};
			`EBP_REG_DUTY_ACTIVE: rdata_d = {24'h000000, duty_act_q[9:2]};
			`EBP_REG_PERIOD:      rdata_d = {24'h000000, period_q};
			`EBP_REG_ALT_PERIOD:  rdata_d = {24'h000000, alt_period_q};
			`EBP_REG_DEADBAND:    rdata_d = {25'h0000000, db_reg_q};
			`EBP_REG_TSEL:        rdata_d = {30'h00000000, tsel_q};
			`EBP_REG_TCTRL:       rdata_d = {22'h000000, tctrl_q};
			`EBP_REG_CMP:         rdata_d = {16'h0000, cmp_q};
			`EBP_REG_T16A:        rdata_d = {16'h0000, t16a_q};
			`EBP_REG_T16B:        rdata_d = {16'h0000, t16b_q};
			`EBP_REG_STATUS:      rdata_d = {20'h00000, pt, 4'h0} | {28'h0000000, status_q};
			`EBP_REG_PINDIR:      rdata_d = {28'h0000000, pindir_q};
			default:              rdata_d = 32'h00000000;
		endcase
	end

	// one wait state on every access
	always_ff @(posedge MCLK) begin
		if (RESET)
			bus_q <= EBP_BUS_IDLE;
		else if (acc && bus_q == EBP_BUS_IDLE)
			bus_q <= EBP_BUS_ACK;
		else
			bus_q <= EBP_BUS_IDLE;
	end

	always_ff @(posedge MCLK) begin
		if (RESET)
			rdata_q <= 32'h00000000;
		else if (AVS_REQ.read && bus_q == EBP_BUS_IDLE)
			rdata_q <= rdata_d;
	end

	// software registers; duty reload writes are accepted at any time
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			ctrl_q       <= `EBP_CTRL_RST;
			reload_q     <= 8'h00;
			period_q     <= `EBP_PERIOD_RST;
			alt_period_q <= `EBP_PERIOD_RST;
			db_reg_q     <= 7'h00;
			tsel_q       <= 2'h0;
			tctrl_q      <= `EBP_TCTRL_RST;
			cmp_q        <= 16'h0000;
			pindir_q     <= `EBP_PINDIR_RST;
		end else if (wr_lo) begin
			case (adr)
				`EBP_REG_CTRL:        ctrl_q       <= wd[7:0];
				`EBP_REG_DUTY_RELOAD: reload_q     <= wd[7:0];
				`EBP_REG_PERIOD:      period_q     <= wd[7:0];
				`EBP_REG_ALT_PERIOD:  alt_period_q <= wd[7:0];
				`EBP_REG_DEADBAND:    db_reg_q     <= wd[6:0];
				`EBP_REG_TSEL:        tsel_q       <= wd[1:0];
				`EBP_REG_PINDIR:      pindir_q     <= wd[3:0];
				default: begin
				end
			endcase
		end
		if (!RESET && wr && adr == `EBP_REG_TCTRL)
			tctrl_q <= {be[1] ? wd[9:8] : tctrl_q[9:8], be[0] ? wd[7:0] : tctrl_q[7:0]};
		if (!RESET && wr && adr == `EBP_REG_CMP)
			cmp_q <= cmp_wr;
	end

	// status flags: write one to clear, a new event in the same cycle wins
	always_ff @(posedge MCLK) begin
		if (RESET)
			status_q <= 4'h0;
		else begin
			status_q <= (wr_lo && adr == `EBP_REG_STATUS) ? (status_q & ~wd[3:0]) : status_q;
			if (cmp_hit)
				status_q[`EBP_STAT_CMP] <= 1'b1;
			if (ovf_a)
				status_q[`EBP_STAT_OVF_A] <= 1'b1;
			if (ovf_b)
				status_q[`EBP_STAT_OVF_B] <= 1'b1;
			if (post_hit)
				status_q[`EBP_STAT_POST] <= 1'b1;
		end
	end

	// quarter cycle, prescaler and the two 8-bit period timers
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			qcyc_q    <= 2'h0;
			presc_q   <= 4'h0;
			tmr_p_q   <= 8'h00;
			tmr_alt_q <= 8'h00;
			post_q    <= 4'h0;
		end else begin
			qcyc_q <= qcyc_q + 2'h1;
			if (icyc)
				presc_q <= (presc_q >= pre_max) ? 4'h0 : presc_q + 4'h1;
			// timer clears on the increment after the limit
			if (ptick)
				tmr_p_q <= wrap_p ? 8'h00 : tmr_p_q + 8'h01;
			if (ptick)
				tmr_alt_q <= wrap_alt ? 8'h00 : tmr_alt_q + 8'h01;
			if (wrap_p)
				post_q <= post_hit ? 4'h0 : post_q + 4'h1;
		end
	end

	// 16-bit timers: software write, then trigger clear, then count
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			t16a_q <= 16'h0000;
			t16b_q <= 16'h0000;
		end else begin
			if (wr && adr == `EBP_REG_T16A)
				t16a_q <= t16a_wr;
			// no overflow flag from this clear
			else if (clr_a)
				t16a_q <= 16'h0000;
			else if (t16a_run && icyc)
				t16a_q <= t16a_q + 16'h0001;
			if (wr && adr == `EBP_REG_T16B)
				t16b_q <= t16b_wr;
			else if (clr_b)
				t16b_q <= 16'h0000;
			else if (t16b_run && icyc)
				t16b_q <= t16b_q + 16'h0001;
		end
	end

	// compare edge and converter start pulse
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			match_prev_q <= 1'b0;
			adc_q        <= 1'b0;
		end else begin
			match_prev_q <= match_now;
			// conversion start only from the second unit, converter enabled
			adc_q        <= trig & HAS_ADC & ADC_ENABLE;
		end
	end

	// pwm shadow registers and raw waveform
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			sh_ctrl_q  <= `EBP_CTRL_RST;
			duty_act_q <= 10'h000;
			run_q      <= 1'b0;
			raw_q      <= 1'b0;
		end else if (boundary) begin
			// controls take effect only at the period boundary
			sh_ctrl_q  <= ctrl_q;
			// active duty loads at a period match, or from an active duty write outside pwm mode
			duty_act_q <= duty_new;
			run_q      <= pwm_mode;
			// output set in pwm mode unless the new duty is zero
			raw_q      <= pwm_mode & (duty_new != 10'h000);
		end else begin
			if (!pwm_mode && wr_lo && adr == `EBP_REG_DUTY_ACTIVE)
				duty_act_q[9:2] <= wd[7:0];
			if (duty_hit)
				raw_q <= 1'b0;
		end
	end

	// lag line, dead-band counter and registered outputs
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			lag_q      <= '0;
			mod_prev_q <= 1'b0;
			db_cnt_q   <= 9'h000;
			db_act_q   <= 7'h00;
			out_q      <= '0;
		end else begin
			lag_q      <= {lag_q[`EBP_DELAY_TAPS-2:0], raw_now};
			mod_prev_q <= mod;
			if (mod != mod_prev_q)
				db_cnt_q <= 9'h001;
			else if (db_cnt_q != `EBP_DB_CNT_MAX)
				db_cnt_q <= db_cnt_q + 9'h001;
			// dead band loads at every period boundary and at the duty match that ends the pulse
			if (boundary || (duty_hit && raw_q))
				db_act_q <= db_reg_q;
			out_q <= out_d;
		end
	end

	// outputs
	assign AVS_WAITREQUEST = acc & ~ack;
	assign AVS_READDATA    = rdata_q;
	assign ADC_START       = adc_q;
	assign BRIDGE_OUT      = out_q;
	// a cleared direction bit turns the pin into an output
	assign BRIDGE_OE       = {~pindir_q[0], ~pindir_q[1], ~pindir_q[2], ~pindir_q[3]};

endmodule

// ===== test/ebp_top_properties.sv
// port assertions of the bridge pwm unit, bound into ebp_top
// assumes one clock MCLK and a synchronous active-high RESET
`timescale 1ns/1ns
`include "ebp_defs.svh"
module ebp_checker #(
	parameter int UNIT_INDEX = 1
) (
	// clock and reset
	input wire logic                     MCLK,
	input wire logic                     RESET,
	// register bus
	input wire ebp_pkg::ebp_avs_req_type AVS_REQ,
	input wire logic [31:0]              AVS_READDATA,
	input wire logic                     AVS_WAITREQUEST,
	// converter link
	input wire logic                     ADC_ENABLE,
	input wire logic                     ADC_START,
	// bridge drivers
	input wire ebp_pkg::ebp_bridge_type  BRIDGE_OUT,
	input wire ebp_pkg::ebp_bridge_type  BRIDGE_OE
);
	import ebp_pkg::*;
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (RESET);
	logic [1:0] pol_q;
	wire        ctrl_take;
	wire        pol_plain;
	// leg checks only hold for active-high drives, so polarity is snooped from control writes
	assign ctrl_take = AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.address == `EBP_REG_CTRL;
	assign pol_plain = pol_q == 2'h0;
	always_ff @(posedge MCLK) begin
		if (RESET || ctrl_take)
			pol_q <= RESET ? 2'h0 : AVS_REQ.writedata[1:0];
	end
	sequence req_wait_s;
		(AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST;
	endsequence
	sequence req_ack_s;
		(AVS_REQ.read || AVS_REQ.write) && !AVS_WAITREQUEST;
	endsequence
	bus_ack_a: assert property (req_wait_s |=> req_ack_s)
		else $error("bus answer not after one wait state");
	read_hold_a: assert property ($changed(AVS_READDATA) |-> $past(AVS_REQ.read) || $past(RESET))
		else $error("read data moved without a read");
	start_pulse_a: assert property (ADC_START |=> !ADC_START [*3])
		else $error("conversion start longer than one pulse");
	start_gate_a: assert property (ADC_START |-> UNIT_INDEX == 2 && ($past(ADC_ENABLE) || $past(ADC_ENABLE, 2)))
		else $error("conversion start without enabled converter");
	oe_write_a: assert property ($changed(BRIDGE_OE) |->
		$past(AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.address == `EBP_REG_PINDIR) || $past(RESET))
		else $error("pin enables moved without a write");
	reset_quiet_a: assert property (disable iff (1'b0) RESET |=> BRIDGE_OUT == 4'h0 && BRIDGE_OE == 4'h0 && !ADC_START)
		else $error("outputs active after reset");
	leg_ab_a: assert property (pol_plain |-> !(BRIDGE_OUT.a && BRIDGE_OUT.b))
		else $error("outputs a and b active together");
	leg_cd_a: assert property (pol_plain |-> !(BRIDGE_OUT.c && BRIDGE_OUT.d))
		else $error("outputs c and d active together");
endmodule

bind ebp_top ebp_checker #(.UNIT_INDEX(UNIT_INDEX)) checker_i (
	.MCLK           (MCLK),
	.RESET          (RESET),
	.AVS_REQ        (AVS_REQ),
	.AVS_READDATA   (AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST),
	.ADC_ENABLE     (ADC_ENABLE),
	.ADC_START      (ADC_START),
	.BRIDGE_OUT     (BRIDGE_OUT),
	.BRIDGE_OE      (BRIDGE_OE)
);

// ===== test/ebp_switch_model.sv
// power switch driver model for two bridge legs, a with b and c with d
// assumes active-high gate inputs; a released pin leaves its switch off
`timescale 1ns/1ns
module ebp_switch_model (
	// clock
	input wire logic                    clk,
	// gate drives
	input wire ebp_pkg::ebp_bridge_type out,
	input wire ebp_pkg::ebp_bridge_type oe,
	// shoot-through cycles seen
	output int                          shoot_cnt
);
	import ebp_pkg::*;
	ebp_bridge_type on;
	// driver pull-downs turn a switch off when its pin is not driven
	assign on = out & oe;
	initial shoot_cnt = 0;
	always @(posedge clk)
		if ((on.a && on.b) || (on.c && on.d))
			shoot_cnt <= shoot_cnt + 1;
endmodule

// ===== test/ebp_top_tb.sv
// self-checking bench of the bridge pwm unit against a counting model
// assumes the avalon slave answers after one wait state
`timescale 1ns/1ns
`include "ebp_defs.svh"
module ebp_top_tb;
	import ebp_pkg::*;
	logic            mclk;
	logic            reset;
	ebp_avs_req_type req;
	logic [31:0]     rdat;
	logic            waitreq;
	logic            adc_en;
	logic            adc_go;
	ebp_bridge_type  bout;
	ebp_bridge_type  boe;
	logic [3:0]      bv;
	logic [31:0]     r;
	logic [31:0]     rdat3;
	logic [31:0]     r3;
	int              shoot;
	int              num_errors;
	int              total_checks;
	int              cfg, pre, duty, db, mode, tot, dp;
	logic [7:0]      ra [6] = '{`EBP_REG_CTRL, `EBP_REG_PERIOD, `EBP_REG_ALT_PERIOD, `EBP_REG_PINDIR, `EBP_REG_TCTRL, 8'h3c};
	logic [31:0]     rv [6] = '{32'h0, 32'hff, 32'hff, 32'hf, 32'h0, 32'h0};
	assign bv = bout;
	ebp_top #(.UNIT_INDEX(2)) dut (.MCLK(mclk), .RESET(reset), .AVS_REQ(req), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(waitreq), .ADC_ENABLE(adc_en), .ADC_START(adc_go), .BRIDGE_OUT(bout), .BRIDGE_OE(boe));
	// a unit with no trigger shares the bus; a match must never clear its timer
	ebp_top #(.UNIT_INDEX(3)) dut3 (.MCLK(mclk), .RESET(reset), .AVS_REQ(req), .AVS_READDATA(rdat3),
		.AVS_WAITREQUEST(), .ADC_ENABLE(adc_en), .ADC_START(), .BRIDGE_OUT(), .BRIDGE_OE());
	ebp_switch_model drv (.clk(mclk), .out(bout), .oe(boe), .shoot_cnt(shoot));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic close_out;
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic bound(input int n);
		if (n >= 3000) begin
			chk("wait bound", 32'h0, 32'h1);
			close_out();
		end
	endtask
	// request held until waitrequest is seen low; one idle edge keeps drives apart
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		req <= '{ad, !wr, wr, 4'hf, wd};
		do begin
			@(posedge mclk);
			n++;
		end while (waitreq !== 1'b0 && n < 3000);
		r = rdat;
		r3 = rdat3;
		req.read <= 1'b0;
		req.write <= 1'b0;
		@(posedge mclk);
		bound(n);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string nm);
		bus(1'b0, ad, 32'h0);
		chk(nm, exp, r);
	endtask
	task automatic rst;
		reset <= 1'b1;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic highs(input int s, input int n, output int h);
		h = 0;
		repeat (n) begin
			@(posedge mclk);
			h += (bv[s] === 1'b1);
		end
	endtask
	task automatic span(input int s, output int t);
		int n;
		n = 0;
		t = 0;
		while (bv[s] !== 1'b0 && n < 3000) begin @(posedge mclk); n++; end
		while (bv[s] !== 1'b1 && n < 3000) begin @(posedge mclk); n++; end
		while (bv[s] !== 1'b0 && n < 3000) begin @(posedge mclk); n++; t++; end
		while (bv[s] !== 1'b1 && n < 3000) begin @(posedge mclk); n++; t++; end
		bound(n);
	endtask
	task automatic gap(output int t);
		int n;
		n = 0;
		t = 0;
		do begin @(posedge mclk); n++; end while (adc_go !== 1'b1 && n < 3000);
		do begin @(posedge mclk); n++; t++; end while (adc_go !== 1'b1 && n < 3000);
		bound(n);
	endtask
	// high cycles per period of output s (3=a, 2=b, 1=c, 0=d)
	function automatic int model(int s);
		int m, x;
		m = (duty == 0) ? 0 : (dp > tot) ? tot : dp;
		case (cfg)
			0: x = (s == 3) ? m : 0;
			1: x = (s == 3) ? tot : (s == 0) ? m : 0;
			2: x = (s == 3) ? m - 4 * db : (s == 2) ? tot - m - 4 * db : 0;
			default: x = (s == 1) ? tot : (s == 2) ? m : 0;
		endcase
		if (x < 0)
			x = 0;
		if ((s % 2) ? mode[1] : mode[0])
			x = tot - x;
		return x;
	endfunction
	task automatic run(input int c, input int p, input int lim, input int d, input int n, input int md);
		int h, t, s0, ms, alt, nd;
		cfg = c;
		duty = d;
		db = n;
		mode = md;
		pre = (p == 0) ? 1 : (p == 1) ? 4 : 16;
		tot = 4 * (lim + 1) * pre;
		dp = d * pre;
		alt = $urandom % 2;
		nd = $urandom % 256;
		rst();
		s0 = shoot;
		bus(1'b1, `EBP_REG_PINDIR, 32'h0);
		chk("pin enables", 32'hf, 32'(boe));
		bus(1'b1, alt ? `EBP_REG_ALT_PERIOD : `EBP_REG_PERIOD, 32'(lim));
		bus(1'b1, alt ? `EBP_REG_PERIOD : `EBP_REG_ALT_PERIOD, 32'(lim + 3));
		bus(1'b1, `EBP_REG_TSEL, 32'(alt));
		bus(1'b1, `EBP_REG_DEADBAND, 32'(n));
		bus(1'b1, `EBP_REG_DUTY_RELOAD, 32'(d >> 2));
		bus(1'b1, `EBP_REG_CTRL, 32'({c[1:0], d[1:0], md[3:0]}));
		bus(1'b1, `EBP_REG_TCTRL, 32'(4 + p + 8 * ($urandom % 16)));
		repeat (2 * tot) @(posedge mclk);
		ms = (c == 1) ? 0 : (c == 3) ? 2 : 3;
		if (model(ms) > 0 && model(ms) < tot) begin
			span(ms, t);
			chk("pwm period", 32'(tot), 32'(t));
		end
		for (int s = 0; s < 4; s++) begin
			highs(s, 2 * tot, h);
			chk("output highs", 32'(2 * model(s)), 32'(h));
		end
		if (md == 12)
			chk("leg overlap", 32'h0, 32'(shoot - s0));
		bus(1'b1, `EBP_REG_TCTRL, 32'(p));
		bus(1'b1, `EBP_REG_DUTY_RELOAD, 32'(nd));
		bus(1'b1, `EBP_REG_DUTY_ACTIVE, 32'(~nd & 255));
		rd(`EBP_REG_DUTY_ACTIVE, 32'(d >> 2), "active duty");
		bus(1'b1, `EBP_REG_TCTRL, 32'(4 + p));
		repeat (tot + 8) @(posedge mclk);
		rd(`EBP_REG_DUTY_ACTIVE, 32'(nd), "active duty");
	endtask
	initial begin
		int lim, c, h, t;
		reset = 1'b1;
		req = '0;
		adc_en = 1'b0;
		void'($urandom(32'h7f5b5cf1));
		rst();
		foreach (ra[i])
			rd(ra[i], rv[i], "reset value");
		c = 5 + $urandom % 10;
		adc_en <= 1'b1;
		bus(1'b1, `EBP_REG_CMP, 32'(c));
		bus(1'b1, `EBP_REG_CTRL, 32'hb);
		bus(1'b1, `EBP_REG_TCTRL, 32'h80);
		gap(t);
		chk("trigger spacing", 32'h1, 32'(t == 4 * c || t == 4 * (c + 1)));
		bus(1'b0, `EBP_REG_T16A, 32'h0);
		chk("timer bound", 32'h1, 32'(c >= r));
		chk("no trigger unit", 32'h1, 32'(r3 > c));
		bus(1'b0, `EBP_REG_STATUS, 32'h0);
		chk("overflow flag", 32'h0, 32'(r[`EBP_STAT_OVF_A]));
		adc_en <= 1'b0;
		h = 0;
		repeat (8 * (c + 1)) begin
			@(posedge mclk);
			h += (adc_go === 1'b1);
		end
		chk("start while disabled", 32'h0, 32'(h));
		bus(1'b1, `EBP_REG_CTRL, 32'ha);
		repeat (8 * (c + 1)) @(posedge mclk);
		bus(1'b0, `EBP_REG_T16A, 32'h0);
		chk("compare keeps timer", 32'h1, 32'(r > c));
		for (int i = 0; i < 4; i++) begin
			lim = 4 + $urandom % 6;
			run(i, i % 3, lim, 5 + $urandom % (4 * lim - 8), (i == 2) ? 1 + $urandom % 2 : 0, 12);
		end
		run(0, 0, 5, 0, 0, 12);
		run(0, 1, 5, 30, 0, 12);
		run(2, 0, 7, 6, 3, 12);
		run(0, 2, 6, 9, 0, 15);
		close_out();
	end
endmodule
